// *** bench/seq_int_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sequencer_interrupt_ctrl_regs_tb_top;
    // bench drive and observe
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hready = 1'b1, entry_wr = 1'b0, unlock = 1'b0;
    logic [1:0] htrans = 2'h0, buf_cmd = 2'h0;
    logic [2:0] hsize = 3'h2, pend = 3'h0;
    logic [3:0] flag_in = 4'h0;
    logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000;
    logic [31:0] low_ev = 32'h00000000, high_ev = 32'h00000000;
    wire logic [31:0] hrdata, low_out, high_out, mask_out;
    wire logic hreadyout, hresp, entry_lock, buf_en, t0, t1, exc_en, global_interrupt_enable;
    wire logic [3:0] flag_out, flag_oe, edge_sel;
    logic [31:0] exp_q[$];
    logic rd_pend = 1'b0;
    int err_count = 0;
    int checks = 0;
    logic [31:0] flag_m, low_m, high_m, r;
    // interrupt control patterns: all ones, each timer alone, selects only
    logic [31:0] ictl_v[4] = '{32'hFFFFFFFF, 32'h00000010, 32'h00000020, 32'h00000005};
    logic en_m, lk_m;
    sequencer_interrupt_ctrl_regs dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout),
        .HRESP_OUT(hresp), .BUF_CMD_IN(buf_cmd), .BUF_UNLOCK_IN(unlock),
        .BUF_ENTRY_WRITE_IN(entry_wr), .BUF_ENTRY_LOCK_OUT(entry_lock), .BUF_ENABLE_OUT(buf_en),
        .PEND_MASK_IN(pend), .FLAG_PIN_IN(flag_in), .FLAG_PIN_OUT(flag_out),
        .FLAG_PIN_OE_OUT(flag_oe), .LATCH_LOW_EVENT_IN(low_ev), .LATCH_HIGH_EVENT_IN(high_ev),
        .LATCH_LOW_OUT(low_out), .LATCH_HIGH_OUT(high_out), .MASK_HIGH_OUT(mask_out),
        .IRQ_EDGE_SEL_OUT(edge_sel), .TIMER0_RUN_OUT(t0), .TIMER1_RUN_OUT(t1),
        .EXC_ENABLE_OUT(exc_en), .GIE_OUT(global_interrupt_enable));
    // clock
    initial begin
        forever #5 clk = ~clk;
    end
    // one compare for every kind of result
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    // single ahb-lite transfer; the master waits on hreadyout, never on a fixed count
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wr ? d : $urandom();
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h00000000);
    endtask : rd
    // read data is judged when its data phase completes
    always @(posedge clk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            if (exp_q.size() == 0) cmp("read queue", 32'h00000001, 32'h00000000);
            else cmp("hrdata", exp_q.pop_front(), hrdata);
        end
        if (hreadyout === 1'b1) rd_pend <= hsel && htrans[1] && !hwrite;
    end
    function automatic logic [31:0] stat();
        return (32'(lk_m) << seq_int_pkg::BUF_LOCK_BIT) | (32'(en_m) << seq_int_pkg::BUF_EN_BIT)
            | (32'(pend) << seq_int_pkg::PEND_HWI_BIT) | 32'(flag_in);
    endfunction : stat
    task automatic bcmd(input logic [1:0] c, input logic u);
        @(posedge clk);
        buf_cmd <= c;
        unlock <= u;
        @(posedge clk);
        buf_cmd <= seq_int_pkg::BUF_CMD_NONE;
        unlock <= 1'b0;
    endtask : bcmd
    // watchdog: the whole sequence needs well under this
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    initial begin
        void'($urandom(94));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        en_m = 1'b0;
        lk_m = 1'b0;
        // every register and three unmapped places read zero after reset
        for (int a = 0; a <= 'h3C; a += 4) rd(8'(a), 32'h00000000);
        rd(8'hFC, 32'h00000000);
        cmp("hresp", 32'h00000000, 32'(hresp));
        // sequencer control enables and reserved field
        bus(1'b1, seq_int_pkg::SEQ_CONTROL_ADDR, 32'hFFFFFFFF);
        rd(seq_int_pkg::SEQ_CONTROL_ADDR, seq_int_pkg::SEQ_CTRL_MASK);
        cmp("exc gie", 32'h00000003, {30'h0, exc_en, global_interrupt_enable});
        bus(1'b1, seq_int_pkg::SEQ_CONTROL_ADDR, 32'h00000004);
        // write lands on the edge that ends the task; let it settle
        @(posedge clk);
        cmp("exc gie", 32'h00000001, {30'h0, exc_en, global_interrupt_enable});
        // flag control through direct write and both aliases
        flag_m = 32'h00000000;
        for (int i = 0; i < 6; i++) begin
            r = $urandom();
            case (i % 3)
                0: begin
                    bus(1'b1, seq_int_pkg::FLAG_CTRL_ADDR, r);
                    flag_m = r & seq_int_pkg::FLAG_CTRL_MASK;
                end
                1: begin
                    bus(1'b1, seq_int_pkg::FLAG_SET_ADDR, r);
                    flag_m = flag_m | (r & seq_int_pkg::FLAG_CTRL_MASK);
                end
                default: begin
                    bus(1'b1, seq_int_pkg::FLAG_CLR_ADDR, r);
                    flag_m = flag_m & ~r;
                end
            endcase
            rd(seq_int_pkg::FLAG_CTRL_ADDR, flag_m);
            cmp("flag value", 32'(flag_m[7:4]), 32'(flag_out));
            cmp("flag dir", 32'(flag_m[3:0]), 32'(flag_oe));
        end
        // latch words, direct, set, clear, then hardware events
        low_m = 32'h00000000;
        high_m = 32'h00000000;
        for (int i = 0; i < 3; i++) begin
            r = $urandom();
            bus(1'b1, seq_int_pkg::LATCH_LOW_ADDR + 8'(i * 4), r);
            bus(1'b1, seq_int_pkg::LATCH_HIGH_ADDR + 8'(i * 4), r);
            low_m = (i == 0) ? r : (i == 1) ? (low_m | r) : (low_m & ~r);
            high_m = ((i == 0) ? r : (i == 1) ? (high_m | r) : (high_m & ~r))
                & seq_int_pkg::HIGH_WORD_MASK;
            rd(seq_int_pkg::LATCH_LOW_ADDR, low_m);
            rd(seq_int_pkg::LATCH_HIGH_ADDR, high_m);
        end
        @(posedge clk);
        low_ev <= 32'h00000101;
        high_ev <= 32'hF0000202;
        @(posedge clk);
        low_ev <= 32'h00000000;
        high_ev <= 32'h00000000;
        @(posedge clk);
        cmp("latch low", low_m | 32'h00000101, low_out);
        cmp("latch high", high_m | 32'h00000202, high_out);
        bus(1'b1, seq_int_pkg::MASK_HIGH_ADDR, 32'hFFFFFFFF);
        rd(seq_int_pkg::MASK_HIGH_ADDR, seq_int_pkg::HIGH_WORD_MASK);
        cmp("mask high", seq_int_pkg::HIGH_WORD_MASK, mask_out);
        bus(1'b1, seq_int_pkg::PEND_HIGH_ADDR, 32'hFFFFFFFF);
        rd(seq_int_pkg::PEND_HIGH_ADDR, seq_int_pkg::HIGH_WORD_MASK);
        // sense selects and timer run bits, four patterns in turn
        foreach (ictl_v[k]) begin
            r = ictl_v[k];
            bus(1'b1, seq_int_pkg::INT_CTRL_ADDR, r);
            rd(seq_int_pkg::INT_CTRL_ADDR, r & seq_int_pkg::INT_CTRL_MASK);
            cmp("edge sel", 32'(r[3:0]), 32'(edge_sel));
            cmp("timers", 32'(r[5:4]), {30'h0, t1, t0});
        end
        // buffer enable and lock in the status word
        for (int p = 0; p < 8; p++) begin
            pend <= 3'(p);
            flag_in <= 4'($urandom());
            bcmd((p == 2) ? 2'h1 : (p == 4) ? 2'h3 : (p == 6) ? 2'h2 : 2'h0, p == 5);
            en_m = (p >= 2 && p < 6);
            lk_m = (p == 4);
            repeat (3) @(posedge clk);
            bus(1'b1, seq_int_pkg::SEQ_STATUS_ADDR, 32'hFFFFFFFF);
            rd(seq_int_pkg::SEQ_STATUS_ADDR, stat());
            cmp("buf enable", 32'(en_m), 32'(buf_en));
            @(posedge clk);
            entry_wr <= 1'b1;
            #1 cmp("entry lock", 32'(lk_m), 32'(entry_lock));
            @(posedge clk);
            entry_wr <= 1'b0;
        end
        // lock wins over unlock in the same cycle
        bcmd(seq_int_pkg::BUF_CMD_LOCK, 1'b1);
        lk_m = 1'b1;
        rd(seq_int_pkg::SEQ_STATUS_ADDR, stat());
        rd(seq_int_pkg::FLAG_CTRL_ADDR, flag_m);
        repeat (2) @(posedge clk);
        cmp("queue left", 32'h00000000, 32'(exp_q.size()));
        wrap_up();
    end
endmodule : sequencer_interrupt_ctrl_regs_tb_top
`default_nettype wire

// *** hw/seq_int_pkg.sv ***
// Contract
// RULE_01: the sequencer status word shows buffer enable at bit 28 and buffer lock at bit 29.
// RULE_02: the buffer enable status reads one exactly while the branch target buffer is enabled.
// RULE_03: while lock status is one, every new buffer entry is written with its lock bit set.
// RULE_04: the status word shows emulation, exception and interrupt pending masks at 22, 21, 20.
// RULE_05: flag pin control holds the direction of flags 3..0 at bits 3..0.
// RULE_06: flag pin control holds the output value of flags 3..0 at bits 7..4.
// RULE_07: the flag set alias sets and the flag clear alias clears flag pin control bits.
// RULE_08: flag input states stay in the sequencer status word, not in flag pin control.
// RULE_09: set and clear aliases act on the low interrupt latch word.
// RULE_10: set and clear aliases act on the high interrupt latch word the same way.
// RULE_11: bits 31:28 of high latch, high mask and high pending mask carry no function.
// RULE_12: interrupt control holds edge or level selects of requests 3..0 at bits 3..0.
// RULE_13: interrupt control holds timer 1 run at bit 5 and timer 0 run at bit 4.
// RULE_14: every other interrupt control bit is reserved and reads zero.
// RULE_15: sequencer control holds exception enable at bit 3 and global enable at bit 2.
// RULE_16: sequencer control bits 27 to 16 are reserved.
// RULE_17: alias writes touch only the bits written as one.
package seq_int_pkg;
    // register byte addresses
    localparam logic [7:0] SEQ_STATUS_ADDR = 8'h00;
    localparam logic [7:0] SEQ_CONTROL_ADDR = 8'h04;
    localparam logic [7:0] FLAG_CTRL_ADDR = 8'h08;
    localparam logic [7:0] FLAG_SET_ADDR = 8'h0C;
    localparam logic [7:0] FLAG_CLR_ADDR = 8'h10;
    localparam logic [7:0] LATCH_LOW_ADDR = 8'h14;
    localparam logic [7:0] LATCH_LOW_SET_ADDR = 8'h18;
    localparam logic [7:0] LATCH_LOW_CLR_ADDR = 8'h1C;
    localparam logic [7:0] LATCH_HIGH_ADDR = 8'h20;
    localparam logic [7:0] LATCH_HIGH_SET_ADDR = 8'h24;
    localparam logic [7:0] LATCH_HIGH_CLR_ADDR = 8'h28;
    localparam logic [7:0] MASK_HIGH_ADDR = 8'h2C;
    localparam logic [7:0] PEND_HIGH_ADDR = 8'h30;
    localparam logic [7:0] INT_CTRL_ADDR = 8'h34;
    // sequencer status fields
    localparam int BUF_EN_BIT = 28;
    localparam int BUF_LOCK_BIT = 29;
    localparam int PEND_EMU_BIT = 22;
    localparam int PEND_EXC_BIT = 21;
    localparam int PEND_HWI_BIT = 20;
    localparam int FLAG_IN_LSB = 0;
    // sequencer control fields
    localparam int EXC_EN_BIT = 3;
    localparam int GIE_BIT = 2;
    localparam logic [31:0] SEQ_CTRL_MASK = 32'hF000FFFF;
    // flag control and interrupt control fields
    localparam int FLAG_DIR_LSB = 0;
    localparam int FLAG_VAL_LSB = 4;
    localparam logic [31:0] FLAG_CTRL_MASK = 32'h000000FF;
    localparam logic [31:0] INT_CTRL_MASK = 32'h0000003F;
    localparam logic [31:0] HIGH_WORD_MASK = 32'h0FFFFFFF;
    // reset values
    localparam logic [31:0] ZERO_RESET = 32'h00000000;
    // branch buffer commands
    localparam logic [1:0] BUF_CMD_NONE = 2'h0;
    localparam logic [1:0] BUF_CMD_ENABLE = 2'h1;
    localparam logic [1:0] BUF_CMD_DISABLE = 2'h2;
    localparam logic [1:0] BUF_CMD_LOCK = 2'h3;
endpackage : seq_int_pkg

// *** hw/seq_int_regs.sv ***
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sequencer_interrupt_ctrl_regs (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    // ahb-lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // branch buffer control from sequencer
    input wire logic [1:0] BUF_CMD_IN,
    input wire logic BUF_UNLOCK_IN,
    input wire logic BUF_ENTRY_WRITE_IN,
    output logic BUF_ENTRY_LOCK_OUT,
    output logic BUF_ENABLE_OUT,
    // pending-mask indications from core
    input wire logic [2:0] PEND_MASK_IN,
    // flag pins, input sampled on REF_CLK_IN through two flops
    input wire logic [3:0] FLAG_PIN_IN,
    output logic [3:0] FLAG_PIN_OUT,
    output logic [3:0] FLAG_PIN_OE_OUT,
    // interrupt and timer controls
    input wire logic [31:0] LATCH_LOW_EVENT_IN,
    input wire logic [31:0] LATCH_HIGH_EVENT_IN,
    output logic [31:0] LATCH_LOW_OUT,
    output logic [31:0] LATCH_HIGH_OUT,
    output logic [31:0] MASK_HIGH_OUT,
    output logic [3:0] IRQ_EDGE_SEL_OUT,
    output logic TIMER0_RUN_OUT,
    output logic TIMER1_RUN_OUT,
    output logic EXC_ENABLE_OUT,
    output logic GIE_OUT
);
    logic ap_valid;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] wd;
    logic [31:0] seq_ctrl_reg;
    logic [31:0] flag_ctrl_reg;
    logic [31:0] latch_low_reg;
    logic [31:0] latch_high_reg;
    logic [31:0] mask_high_reg;
    logic [31:0] pend_high_reg;
    logic [31:0] int_ctrl_reg;
    logic buf_en_reg;
    logic buf_lock_reg;
    logic [3:0] flag_meta_reg;
    logic [3:0] flag_sync_reg;
    logic [31:0] status_word;
    logic [31:0] rdata_reg;

    // one function for every alias: ones touch, zeros leave alone
    function automatic logic [31:0] wr_hit(input logic pend, input logic [7:0] a,
                                           input logic [7:0] target, input logic [31:0] d);
        wr_hit = (pend && a == target) ? d : 32'h00000000;
    endfunction : wr_hit

    assign ap_valid = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    assign wd = HWDATA_IN;
    // zero wait state, always okay
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;

    // capture write address phase
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= ap_valid && HWRITE_IN;
            wr_addr_reg <= HADDR_IN[7:0];
        end
    end

    // flag pins cross in through two flops
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            flag_meta_reg <= 4'h0;
            flag_sync_reg <= 4'h0;
        end else begin
            flag_meta_reg <= FLAG_PIN_IN;
            flag_sync_reg <= flag_meta_reg;
        end
    end

    // RULE_15 RULE_16 control with reserved gap
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            seq_ctrl_reg <= seq_int_pkg::ZERO_RESET;
        end else if (wr_pend_reg && wr_addr_reg == seq_int_pkg::SEQ_CONTROL_ADDR) begin
            seq_ctrl_reg <= wd & seq_int_pkg::SEQ_CTRL_MASK;
        end
    end

    // RULE_05 RULE_06 RULE_07 RULE_17 flag control and aliases
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            flag_ctrl_reg <= seq_int_pkg::ZERO_RESET;
        end else if (wr_pend_reg && wr_addr_reg == seq_int_pkg::FLAG_CTRL_ADDR) begin
            flag_ctrl_reg <= wd & seq_int_pkg::FLAG_CTRL_MASK;
        end else begin
            flag_ctrl_reg <= ((flag_ctrl_reg
                | wr_hit(wr_pend_reg, wr_addr_reg, seq_int_pkg::FLAG_SET_ADDR, wd))
                & ~wr_hit(wr_pend_reg, wr_addr_reg, seq_int_pkg::FLAG_CLR_ADDR, wd))
                & seq_int_pkg::FLAG_CTRL_MASK;
        end
    end

    // RULE_09 RULE_17 low latch: hardware event wins over clear
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            latch_low_reg <= seq_int_pkg::ZERO_RESET;
        end else if (wr_pend_reg && wr_addr_reg == seq_int_pkg::LATCH_LOW_ADDR) begin
            latch_low_reg <= wd | LATCH_LOW_EVENT_IN;
        end else begin
            latch_low_reg <= (latch_low_reg
                & ~wr_hit(wr_pend_reg, wr_addr_reg, seq_int_pkg::LATCH_LOW_CLR_ADDR, wd))
                | wr_hit(wr_pend_reg, wr_addr_reg, seq_int_pkg::LATCH_LOW_SET_ADDR, wd)
                | LATCH_LOW_EVENT_IN;
        end
    end

    // RULE_10 RULE_11 high latch, top nibble held at zero
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            latch_high_reg <= seq_int_pkg::ZERO_RESET;
        end else if (wr_pend_reg && wr_addr_reg == seq_int_pkg::LATCH_HIGH_ADDR) begin
            latch_high_reg <= (wd | LATCH_HIGH_EVENT_IN) & seq_int_pkg::HIGH_WORD_MASK;
        end else begin
            latch_high_reg <= ((latch_high_reg
                & ~wr_hit(wr_pend_reg, wr_addr_reg, seq_int_pkg::LATCH_HIGH_CLR_ADDR, wd))
                | wr_hit(wr_pend_reg, wr_addr_reg, seq_int_pkg::LATCH_HIGH_SET_ADDR, wd)
                | LATCH_HIGH_EVENT_IN) & seq_int_pkg::HIGH_WORD_MASK;
        end
    end

    // RULE_11 high mask and pending mask words
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            mask_high_reg <= seq_int_pkg::ZERO_RESET;
            pend_high_reg <= seq_int_pkg::ZERO_RESET;
        end else if (wr_pend_reg && wr_addr_reg == seq_int_pkg::MASK_HIGH_ADDR) begin
            mask_high_reg <= wd & seq_int_pkg::HIGH_WORD_MASK;
        end else if (wr_pend_reg && wr_addr_reg == seq_int_pkg::PEND_HIGH_ADDR) begin
            pend_high_reg <= wd & seq_int_pkg::HIGH_WORD_MASK;
        end
    end

    // RULE_12 RULE_13 RULE_14 interrupt control, reserved masked
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            int_ctrl_reg <= seq_int_pkg::ZERO_RESET;
        end else if (wr_pend_reg && wr_addr_reg == seq_int_pkg::INT_CTRL_ADDR) begin
            int_ctrl_reg <= wd & seq_int_pkg::INT_CTRL_MASK;
        end
    end

    // RULE_02 branch buffer state from sequencer commands, not software
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            buf_en_reg <= 1'b0;
            buf_lock_reg <= 1'b0;
        end else begin
            if (BUF_CMD_IN == seq_int_pkg::BUF_CMD_ENABLE) begin
                buf_en_reg <= 1'b1;
            end else if (BUF_CMD_IN == seq_int_pkg::BUF_CMD_DISABLE) begin
                buf_en_reg <= 1'b0;
            end
            if (BUF_CMD_IN == seq_int_pkg::BUF_CMD_LOCK) begin
                buf_lock_reg <= 1'b1;
            end else if (BUF_UNLOCK_IN) begin
                buf_lock_reg <= 1'b0;
            end
        end
    end

    // RULE_01 RULE_04 RULE_08 status word assembly
    always_comb begin
        status_word = 32'h00000000;
        status_word[seq_int_pkg::BUF_EN_BIT] = buf_en_reg;
        status_word[seq_int_pkg::BUF_LOCK_BIT] = buf_lock_reg;
        status_word[seq_int_pkg::PEND_EMU_BIT] = PEND_MASK_IN[2];
        status_word[seq_int_pkg::PEND_EXC_BIT] = PEND_MASK_IN[1];
        status_word[seq_int_pkg::PEND_HWI_BIT] = PEND_MASK_IN[0];
        status_word[seq_int_pkg::FLAG_IN_LSB +: 4] = flag_sync_reg;
    end

    // read data registered at data phase; aliases and unmapped read zero
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            rdata_reg <= 32'h00000000;
        end else if (ap_valid && !HWRITE_IN) begin
            unique case (HADDR_IN[7:0])
                seq_int_pkg::SEQ_STATUS_ADDR: rdata_reg <= status_word;
                seq_int_pkg::SEQ_CONTROL_ADDR: rdata_reg <= seq_ctrl_reg;
                seq_int_pkg::FLAG_CTRL_ADDR: rdata_reg <= flag_ctrl_reg;
                seq_int_pkg::LATCH_LOW_ADDR: rdata_reg <= latch_low_reg;
                seq_int_pkg::LATCH_HIGH_ADDR: rdata_reg <= latch_high_reg;
                seq_int_pkg::MASK_HIGH_ADDR: rdata_reg <= mask_high_reg;
                seq_int_pkg::PEND_HIGH_ADDR: rdata_reg <= pend_high_reg;
                seq_int_pkg::INT_CTRL_ADDR: rdata_reg <= int_ctrl_reg;
                default: rdata_reg <= 32'h00000000;
            endcase
        end
    end
    assign HRDATA_OUT = rdata_reg;

    // outputs to the core
    // RULE_03 lock stamp on new entries
    assign BUF_ENTRY_LOCK_OUT = buf_lock_reg && BUF_ENTRY_WRITE_IN;
    assign BUF_ENABLE_OUT = buf_en_reg;
    assign FLAG_PIN_OE_OUT = flag_ctrl_reg[seq_int_pkg::FLAG_DIR_LSB +: 4];
    assign FLAG_PIN_OUT = flag_ctrl_reg[seq_int_pkg::FLAG_VAL_LSB +: 4];
    assign LATCH_LOW_OUT = latch_low_reg;
    assign LATCH_HIGH_OUT = latch_high_reg;
    assign MASK_HIGH_OUT = mask_high_reg;
    assign IRQ_EDGE_SEL_OUT = int_ctrl_reg[3:0];
    assign TIMER0_RUN_OUT = int_ctrl_reg[4];
    assign TIMER1_RUN_OUT = int_ctrl_reg[5];
    assign EXC_ENABLE_OUT = seq_ctrl_reg[seq_int_pkg::EXC_EN_BIT];
    assign GIE_OUT = seq_ctrl_reg[seq_int_pkg::GIE_BIT];

    // flag set alias takes effect next cycle
    flag_set_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_07
        (wr_pend_reg && wr_addr_reg == seq_int_pkg::FLAG_SET_ADDR)
        |=> ((flag_ctrl_reg & ($past(wd) & seq_int_pkg::FLAG_CTRL_MASK))
             == ($past(wd) & seq_int_pkg::FLAG_CTRL_MASK)))
        else $error("flag set alias missed");
    flag_clear_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_07
        (wr_pend_reg && wr_addr_reg == seq_int_pkg::FLAG_CLR_ADDR)
        |=> ((flag_ctrl_reg & $past(wd)) == 32'h00000000))
        else $error("flag clear alias missed");
    alias_zeros_keep_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_17
        (wr_pend_reg && wr_addr_reg == seq_int_pkg::FLAG_CLR_ADDR)
        |=> ((flag_ctrl_reg & ~$past(wd)) == ($past(flag_ctrl_reg) & ~$past(wd))))
        else $error("alias disturbed zero bits");
    low_latch_set_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_09
        (wr_pend_reg && wr_addr_reg == seq_int_pkg::LATCH_LOW_SET_ADDR)
        |=> ((latch_low_reg & $past(wd)) == $past(wd)))
        else $error("low latch set missed");
    low_latch_clear_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_09
        (wr_pend_reg && wr_addr_reg == seq_int_pkg::LATCH_LOW_CLR_ADDR)
        |=> ((latch_low_reg & $past(wd) & ~$past(LATCH_LOW_EVENT_IN)) == 32'h00000000))
        else $error("low latch clear missed");
    high_latch_set_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_10
        (wr_pend_reg && wr_addr_reg == seq_int_pkg::LATCH_HIGH_SET_ADDR)
        |=> ((latch_high_reg & $past(wd) & seq_int_pkg::HIGH_WORD_MASK)
             == ($past(wd) & seq_int_pkg::HIGH_WORD_MASK)))
        else $error("high latch set missed");
    high_latch_clear_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_10
        (wr_pend_reg && wr_addr_reg == seq_int_pkg::LATCH_HIGH_CLR_ADDR)
        |=> ((latch_high_reg & $past(wd) & ~$past(LATCH_HIGH_EVENT_IN)) == 32'h00000000))
        else $error("high latch clear missed");
    // an event in the same cycle as a clear must still land
    low_event_wins_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_09
        (LATCH_LOW_EVENT_IN != 32'h00000000)
        |=> ((latch_low_reg & $past(LATCH_LOW_EVENT_IN)) == $past(LATCH_LOW_EVENT_IN)))
        else $error("low latch event lost");
    high_nibble_zero_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_11
        (latch_high_reg[31:28] == 4'h0) && (mask_high_reg[31:28] == 4'h0)
        && (pend_high_reg[31:28] == 4'h0))
        else $error("high word top bits set");
    int_ctrl_rsvd_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_14
        (int_ctrl_reg & ~seq_int_pkg::INT_CTRL_MASK) == 32'h00000000)
        else $error("interrupt control reserved set");
    seq_ctrl_rsvd_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_16
        seq_ctrl_reg[27:16] == 12'h000)
        else $error("control reserved bits set");
    buf_en_tracks_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_02
        (BUF_CMD_IN == seq_int_pkg::BUF_CMD_ENABLE) |=> status_word[28] ##0 BUF_ENABLE_OUT)
        else $error("enable status not set");
    entry_lock_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_03
        (status_word[29] && BUF_ENTRY_WRITE_IN) |-> BUF_ENTRY_LOCK_OUT)
        else $error("entry not locked");
endmodule : sequencer_interrupt_ctrl_regs
`default_nettype wire
